// File: hdl/msm_settings.sv
// Key-driven measurement settings controller with APB register access.
// Assumes keypad lines are asynchronous levels, high while a key is held.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps

module msm_settings
#(
    parameter int unsigned SHOW_CYCLES = msm_pkg::SHOW_TIME_MS * (msm_pkg::CLK_HZ / 1000)
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   clk_en,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire msm_pkg::msm_keys_s     keys_raw,
    output msm_pkg::msm_settings_s      settings,
    output msm_pkg::msm_display_s       display,
    output logic [15:0]                 traverse_len
);
    import msm_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [7:0] wrap_step(input logic [7:0] v, input logic [7:0] last, input logic up);
        if (up) begin
            wrap_step = (v == last) ? 8'h00 : v + 8'h01;
        end else begin
            wrap_step = (v == 8'h00) ? last : v - 8'h01;
        end
    endfunction

    function automatic logic [7:0] sat_step(input logic [7:0] v, input logic [7:0] last, input logic up);
        if (up) begin
            sat_step = (v == last) ? v : v + 8'h01;
        end else begin
            sat_step = (v == 8'h00) ? v : v - 8'h01;
        end
    endfunction

    function automatic logic [15:0] cut_hund(input logic [1:0] c);
        case (c)
            CUT_2P5:  cut_hund = HUND_2P5;
            CUT_0P25: cut_hund = HUND_0P25;
            default:  cut_hund = HUND_0P8;
        endcase
    endfunction

    // Filter follows the standard; only the oldest standard uses the RC filter
    function automatic logic [1:0] std_filter(input logic [2:0] s);
        std_filter = (s == STD_JIS82) ? FIL_2RC : FIL_PC50;
    endfunction

    // ==========================================================
    // Key synchronisers and press detection
    localparam int unsigned NKEYS = $bits(msm_keys_s);
    logic [NKEYS-1:0] key_s1_ff;
    logic [NKEYS-1:0] key_s2_ff;
    logic [NKEYS-1:0] key_prev_ff;
    wire  [NKEYS-1:0] press_vec = key_s2_ff & ~key_prev_ff;
    msm_keys_s        press;
    assign press = msm_keys_s'(press_vec);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_s1_ff   <= '0;
            key_s2_ff   <= '0;
            key_prev_ff <= '0;
        end else if (clk_en) begin
            key_s1_ff   <= keys_raw;
            key_s2_ff   <= key_s1_ff;
            key_prev_ff <= key_s2_ff;
        end
    end

    // ==========================================================
    // State
    msm_menu_e     menu_ff;
    msm_menu_e     nxt_menu;
    logic [7:0]    pend_ff;
    logic [7:0]    nxt_pend;
    msm_settings_s set_ff;
    msm_settings_s nxt_set;
    logic          speed_req_ff;
    logic          nxt_speed_req;
    logic [31:0]   show_cnt_ff;
    logic          show_ff;

    wire arrow     = press.cut_up | press.down;
    wire arrow_up  = press.cut_up;
    wire factory   = psel & penable & pwrite & pready & (paddr == ADDR_CONTROL) & pwdata[CTRL_FACTORY_BIT];

    // Clamp entered arbitrary length on commit
    wire [7:0] len_clamped = (pend_ff < LEN_MIN) ? LEN_MIN :
                             (pend_ff > LEN_MAX) ? LEN_MAX :
                             pend_ff;

    // Speed choice allowed only in these windows, else fixed at 0.5 mm/s
    wire speed_ok = (set_ff.count != CNT_L) ? (set_ff.cutoff == CUT_0P8) :
                    ((set_ff.eval_len >= LEN_SPD_LO) && (set_ff.eval_len <= LEN_SPD_HI));

    // ==========================================================
    // Menu sequencing
    always_comb begin
        nxt_menu = menu_ff;
        nxt_pend = pend_ff;
        nxt_set  = set_ff;
        case (menu_ff)
            ST_MEAS: begin
                if (press.cut_up) begin
                    nxt_set.cutoff = (set_ff.cutoff == CUT_0P25) ? CUT_0P8 : set_ff.cutoff + 2'h1;
                end
                if (press.confirm) begin
                    nxt_set.count = set_ff.count + 2'h1;
                    if (set_ff.count == CNT_5) begin
                        nxt_menu = ST_LEN;
                        nxt_pend = set_ff.eval_len;
                    end
                end else if (press.escape) begin
                    nxt_menu = ST_ESC1;
                end else if (press.calib) begin
                    nxt_menu = ST_CAL;
                end else if (press.profile) begin
                    nxt_menu = ST_PRF;
                    nxt_pend = {6'h00, set_ff.profile};
                end
            end
            ST_LEN: begin
                // Entry saturates at the register span; clamping happens on commit
                if (arrow) begin
                    nxt_pend = sat_step(pend_ff, 8'hFF, arrow_up);
                end
                if (press.confirm) begin
                    nxt_set.eval_len = len_clamped;
                    nxt_menu = ST_MEAS;
                end else if (press.escape) begin
                    nxt_menu = ST_MEAS;
                end
            end
            ST_ESC1: begin
                if (press.escape) begin
                    nxt_menu = ST_PREPOST;
                    nxt_pend = {7'h00, set_ff.prepost};
                end
            end
            ST_PREPOST: begin
                if (arrow) begin
                    nxt_pend = {7'h00, ~pend_ff[0]};
                end
                if (press.confirm) begin
                    nxt_set.prepost = pend_ff[0];
                    nxt_menu = ST_MEAS;
                end else if (press.escape) begin
                    nxt_menu = ST_MEAS;
                end
            end
            ST_CAL: begin
                if (press.calib) begin
                    nxt_menu = ST_STD;
                    nxt_pend = {5'h00, set_ff.standard};
                end else if (press.escape) begin
                    nxt_menu = ST_MEAS;
                end
            end
            ST_STD: begin
                if (arrow) begin
                    nxt_pend = wrap_step(pend_ff, {5'h00, STD_LAST}, arrow_up);
                end
                if (press.confirm) begin
                    nxt_set.standard = pend_ff[2:0];
                    nxt_set.filter   = std_filter(pend_ff[2:0]);
                    nxt_menu = ST_MEAS;
                end else if (press.escape) begin
                    nxt_menu = ST_MEAS;
                end else if (press.calib) begin
                    nxt_menu = ST_RANGE;
                    nxt_pend = {5'h00, set_ff.range};
                end
            end
            ST_RANGE: begin
                if (arrow) begin
                    nxt_pend = sat_step(pend_ff, {5'h00, RNG_LAST}, ~arrow_up);
                end
                if (press.confirm) begin
                    nxt_set.range      = pend_ff[2:0];
                    nxt_set.resolution = pend_ff[2:0];
                    nxt_menu = ST_MEAS;
                end else if (press.escape) begin
                    nxt_menu = ST_MEAS;
                end
            end
            ST_PRF: begin
                if (arrow) begin
                    nxt_pend = wrap_step(pend_ff, {6'h00, PRF_LAST}, arrow_up);
                end
                if (press.confirm) begin
                    nxt_set.profile = pend_ff[1:0];
                    nxt_menu = ST_MEAS;
                end else if (press.escape) begin
                    nxt_menu = ST_MEAS;
                end else if (press.profile) begin
                    nxt_menu = ST_PFL_OTHER;
                end
            end
            ST_PFL_OTHER: begin
                // Filter and limit menus live elsewhere; only leave on escape
                if (press.escape) begin
                    nxt_menu = ST_MEAS;
                end
            end
            default: begin
                nxt_menu = ST_MEAS;
            end
        endcase
        nxt_set.speed = speed_ok ? speed_req_ff : SPD_0P5;
    end

    assign nxt_speed_req = (psel & penable & pwrite & pready & (paddr == ADDR_CONTROL))
                           ? pwdata[CTRL_SPEED_BIT] : speed_req_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            menu_ff                <= ST_MEAS;
            pend_ff                <= '0;
            speed_req_ff           <= SPD_0P5;
            set_ff.cutoff          <= CUT_0P8;
            set_ff.count           <= CNT_5;
            set_ff.eval_len        <= LEN_RESET;
            set_ff.prepost         <= 1'b1;
            set_ff.range           <= RNG_AUTO;
            set_ff.resolution      <= RNG_AUTO;
            set_ff.standard        <= STD_JIS01;
            set_ff.profile         <= PRF_R;
            set_ff.filter          <= FIL_PC50;
            set_ff.speed           <= SPD_0P5;
        end else if (clk_en) begin
            speed_req_ff <= nxt_speed_req;
            if (factory) begin
                // Factory defaults; pre/post inclusion comes back on
                menu_ff            <= ST_MEAS;
                set_ff.cutoff      <= CUT_0P8;
                set_ff.count       <= CNT_5;
                set_ff.eval_len    <= LEN_RESET;
                set_ff.prepost     <= 1'b1;
                set_ff.range       <= RNG_AUTO;
                set_ff.resolution  <= RNG_AUTO;
                set_ff.standard    <= STD_JIS01;
                set_ff.profile     <= PRF_R;
                set_ff.filter      <= FIL_PC50;
                set_ff.speed       <= SPD_0P5;
            end else begin
                menu_ff <= nxt_menu;
                pend_ff <= nxt_pend;
                set_ff  <= nxt_set;
            end
        end
    end

    // ==========================================================
    // Power-on settings display
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            show_cnt_ff <= '0;
            show_ff     <= 1'b1;
        end else if (clk_en && show_ff) begin
            show_cnt_ff <= show_cnt_ff + 32'h1;
            show_ff     <= (show_cnt_ff < (SHOW_CYCLES - 1));
        end
    end

    // ==========================================================
    // Traversing length in 0.01 mm
    wire [15:0] hund     = cut_hund(set_ff.cutoff);
    wire [15:0] eval_hund = (set_ff.count == CNT_1) ? hund :
                            (set_ff.count == CNT_3) ? 16'(hund * 16'h0003) :
                            (set_ff.count == CNT_5) ? 16'(hund * 16'h0005) :
                            16'(set_ff.eval_len * 16'h000A);
    wire [15:0] nxt_trav = set_ff.prepost ? 16'(eval_hund + (hund << 1)) : eval_hund;
    logic [15:0] trav_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trav_ff <= '0;
        end else if (clk_en) begin
            trav_ff <= nxt_trav;
        end
    end

    // ==========================================================
    // APB slave, no wait states; pready is high in the first access cycle
    // Writes to read-only offsets are dropped silently; only unmapped ones raise pslverr
    logic        pready_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;
    wire         hit_set  = (paddr == ADDR_SETTINGS);
    wire         hit_ctl  = (paddr == ADDR_CONTROL);
    wire         hit_sts  = (paddr == ADDR_STATUS);
    wire         hit_trav = (paddr == ADDR_TRAVERSE);
    wire         mapped   = hit_set | hit_ctl | hit_sts | hit_trav;
    wire [31:0]  rd_mux   = hit_set  ? 32'(set_ff) :
                            hit_ctl  ? {31'h0, speed_req_ff} :
                            hit_sts  ? {19'h0, show_ff, pend_ff, 4'(menu_ff)} :
                            hit_trav ? {16'h0, trav_ff} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end else if (clk_en) begin
            // Ready only after the slave has seen the request once
            pready_ff  <= psel & ~pready_ff;
            prdata_ff  <= (psel & ~pready_ff & ~pwrite) ? rd_mux : 32'h0;
            pslverr_ff <= psel & ~pready_ff & ~mapped;
        end
    end

    assign pready  = pready_ff;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff;

    // ==========================================================
    // Outputs
    logic [15:0]  trav_out_ff;
    msm_display_s disp_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trav_out_ff <= '0;
            disp_ff     <= '{menu: ST_MEAS, pending: 8'h00, show_all: 1'b1};
        end else if (clk_en) begin
            trav_out_ff <= trav_ff;
            disp_ff     <= '{menu: menu_ff, pending: pend_ff, show_all: show_ff};
        end
    end

    assign settings     = set_ff;
    assign display      = disp_ff;
    assign traverse_len = trav_out_ff;

endmodule

// File: pkg/msm_pkg.sv
// Package for the measurement settings menu: codes, limits, register map, carriers.
// Assumes one 100 MHz clock and a 32-bit APB register port.
package msm_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned SHOW_TIME_MS    = 1000;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0]  ADDR_SETTINGS   = 8'h00;
    localparam logic [7:0]  ADDR_CONTROL    = 8'h04;
    localparam logic [7:0]  ADDR_STATUS     = 8'h08;
    localparam logic [7:0]  ADDR_TRAVERSE   = 8'h0C;
    localparam int unsigned CTRL_SPEED_BIT  = 0;
    localparam int unsigned CTRL_FACTORY_BIT = 1;

    // ==========================================================
    // Option codes
    localparam logic [1:0]  CUT_0P8         = 2'h0;
    localparam logic [1:0]  CUT_2P5         = 2'h1;
    localparam logic [1:0]  CUT_0P25        = 2'h2;
    localparam logic [1:0]  CNT_1           = 2'h0;
    localparam logic [1:0]  CNT_3           = 2'h1;
    localparam logic [1:0]  CNT_5           = 2'h2;
    localparam logic [1:0]  CNT_L           = 2'h3;
    localparam logic [2:0]  RNG_AUTO        = 3'h0;
    localparam logic [2:0]  RNG_LAST        = 3'h4;
    localparam logic [2:0]  STD_JIS01       = 3'h0;
    localparam logic [2:0]  STD_JIS82       = 3'h1;
    localparam logic [2:0]  STD_LAST        = 3'h5;
    localparam logic [1:0]  PRF_R           = 2'h1;
    localparam logic [1:0]  PRF_LAST        = 2'h2;
    localparam logic [1:0]  FIL_2RC         = 2'h0;
    localparam logic [1:0]  FIL_PC50        = 2'h1;
    localparam logic        SPD_0P5         = 1'b0;

    // ==========================================================
    // Lengths: evaluation length in 0.1 mm, traverse in 0.01 mm
    localparam logic [7:0]  LEN_MIN         = 8'h03;
    localparam logic [7:0]  LEN_MAX         = 8'h7D;
    localparam logic [7:0]  LEN_SPD_LO      = 8'h0C;
    localparam logic [7:0]  LEN_SPD_HI      = 8'h28;
    localparam logic [7:0]  LEN_RESET       = 8'h32;
    localparam logic [15:0] HUND_0P8        = 16'h0050;
    localparam logic [15:0] HUND_2P5        = 16'h00FA;
    localparam logic [15:0] HUND_0P25       = 16'h0019;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        ST_MEAS, ST_LEN, ST_CAL, ST_STD, ST_RANGE, ST_ESC1, ST_PREPOST, ST_PRF, ST_PFL_OTHER
    } msm_menu_e;

    typedef struct packed {
        logic cut_up;
        logic down;
        logic confirm;
        logic escape;
        logic calib;
        logic profile;
    } msm_keys_s;

    typedef struct packed {
        logic [1:0] cutoff;
        logic [1:0] count;
        logic [7:0] eval_len;
        logic       prepost;
        logic [2:0] range;
        logic [2:0] resolution;
        logic [2:0] standard;
        logic [1:0] profile;
        logic [1:0] filter;
        logic       speed;
    } msm_settings_s;

    typedef struct packed {
        msm_menu_e  menu;
        logic [7:0] pending;
        logic       show_all;
    } msm_display_s;

endpackage

// File: verif/msm_keypad.sv
// Keypad partner: a user pressing front-panel keys.
// Assumes the bench clock; lines change only after rising edges.
`timescale 1ns/1ps

module msm_keypad (
    input  wire logic          pclk,
    output msm_pkg::msm_keys_s keys_raw
);
    import msm_pkg::*;

    initial keys_raw = '0;

    // Held four edges, released four, so every press is seen as its own event
    task automatic press(input logic [5:0] k, input int n);
        repeat (n) begin
            @(posedge pclk);
            keys_raw <= k;
            repeat (4) @(posedge pclk);
            keys_raw <= '0;
            repeat (4) @(posedge pclk);
        end
    endtask
endmodule

// File: verif/msm_settings_properties.sv
// Port checks for the settings controller.
// Assumes a bind to msm_settings; one clock domain.
`timescale 1ns/1ps

module msm_settings_properties (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  clk_en,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic                  pready,
    input wire msm_pkg::msm_settings_s settings,
    input wire msm_pkg::msm_display_s  display
);
    import msm_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Software factory reset may move any field, so steps after a write are skipped
    wire apb_wr = psel & penable & pwrite;

    // ==========================================================
    // Assertions
    AST_APB_ANSWER: assert property (psel && !penable && !pready && clk_en |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    AST_CUT_CYCLE: assert property ($changed(settings.cutoff) && !$past(apb_wr) |->
        settings.cutoff == (($past(settings.cutoff) == CUT_0P25) ? CUT_0P8 : $past(settings.cutoff) + 2'h1))
        else $error("cutoff stepped out of order");
    AST_COUNT_STEP: assert property ($changed(settings.count) && !$past(apb_wr) |->
        settings.count == $past(settings.count) + 2'h1) else $error("count stepped out of order");
    AST_SPEED_GATE: assert property (settings.speed && $stable(settings.cutoff) && $stable(settings.count)
        && $stable(settings.eval_len) |-> (settings.count != CNT_L && settings.cutoff == CUT_0P8)
        || (settings.count == CNT_L && settings.eval_len >= LEN_SPD_LO && settings.eval_len <= LEN_SPD_HI))
        else $error("slow speed allowed outside its conditions");
    AST_LEN_LIMIT: assert property (settings.eval_len >= LEN_MIN && settings.eval_len <= LEN_MAX)
        else $error("evaluation length out of limits");
    AST_RES_FOLLOW: assert property ($changed(settings.range) |-> settings.resolution == settings.range)
        else $error("resolution not matched to range");
    AST_FILTER_FOLLOW: assert property ($changed(settings.standard) |->
        settings.filter == ((settings.standard == STD_JIS82) ? FIL_2RC : FIL_PC50))
        else $error("filter not matched to standard");
    AST_RANGE_FROM_MENU: assert property ($changed(settings.range) && !$past(apb_wr) |->
        display.menu == ST_RANGE) else $error("range changed outside range setup");
    AST_PREPOST_FROM_MENU: assert property ($changed(settings.prepost) && !$past(apb_wr) |->
        display.menu == ST_PREPOST) else $error("pre/post changed outside its setup");
    AST_RANGE_STEP: assert property (display.menu == ST_RANGE && $past(display.menu) == ST_RANGE
        && $changed(display.pending) |-> display.pending == $past(display.pending) + 8'h01
        || display.pending == $past(display.pending) - 8'h01) else $error("range pending jumped");

    // ==========================================================
    // Covers
    COV_LEN_MENU: cover property (display.menu == ST_LEN);
    COV_SLOW_L: cover property (settings.count == CNT_L && settings.speed);
    COV_STD_LAST: cover property (settings.standard == STD_LAST);
endmodule

// File: verif/test_msm_settings.sv
// Self-checking bench for the settings controller.
// Assumes keypad model and checker compiled first; APB master here.
`timescale 1ns/1ps

module test_msm_settings;
    import msm_pkg::*;

    localparam logic [5:0] K_CUT = 6'h20, K_DN = 6'h10, K_OK = 6'h08;
    localparam logic [5:0] K_ESC = 6'h04, K_CAL = 6'h02, K_PRF = 6'h01;

    logic          pclk = 1'b0;
    logic          presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic [15:0]   traverse_len;
    msm_keys_s     keys_raw;
    msm_settings_s settings;
    msm_display_s  display;
    int            fail_count = 0;
    int            comparisons = 0;

    always #5 pclk = ~pclk;

    msm_keypad u_kp (.pclk(pclk), .keys_raw(keys_raw));

    // Short show time keeps the power-on display check quick
    msm_settings #(.SHOW_CYCLES(20)) u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .keys_raw(keys_raw), .settings(settings), .display(display),
        .traverse_len(traverse_len));

    // ==========================================================
    // Shared tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) fail_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk("prepost", settings.prepost, 1);
        chk("traverse", traverse_len, 16'h0230);
        chk("show", display.show_all, 1);
        repeat (25) @(posedge pclk);
        chk("show", display.show_all, 0);
    endtask

    task automatic t_cut();
        logic [1:0] exp [3] = '{CUT_2P5, CUT_0P25, CUT_0P8};
        for (int i = 0; i < 3; i++) begin
            u_kp.press(K_CUT, 1);
            chk("cutoff", settings.cutoff, exp[i]);
        end
        clk_en <= 1'b0;
        u_kp.press(K_CUT, 1);
        clk_en <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("cutoff", settings.cutoff, CUT_0P8);
    endtask

    task automatic t_speed();
        apb(1'b1, ADDR_CONTROL, 32'h1);
        chk("speed", settings.speed, 1);
        u_kp.press(K_CUT, 1);
        chk("speed", settings.speed, 0);
        u_kp.press(K_CUT, 2);
        chk("speed", settings.speed, 1);
    endtask

    task automatic t_prepost();
        u_kp.press(K_ESC, 2);
        u_kp.press(K_DN, 1);
        u_kp.press(K_ESC, 1);
        chk("prepost", settings.prepost, 1);
        u_kp.press(K_ESC, 2);
        chk("menu", display.menu, ST_PREPOST);
        u_kp.press(K_CUT, 1);
        u_kp.press(K_OK, 1);
        chk("prepost", settings.prepost, 0);
        chk("menu", display.menu, ST_MEAS);
        chk("traverse", traverse_len, 16'h0190);
        u_kp.press(K_ESC, 2);
        u_kp.press(K_DN, 1);
        u_kp.press(K_OK, 1);
        chk("prepost", settings.prepost, 1);
    endtask

    task automatic t_len();
        u_kp.press(K_OK, 1);
        chk("count", settings.count, CNT_L);
        chk("menu", display.menu, ST_LEN);
        u_kp.press(K_DN, 38);
        u_kp.press(K_OK, 1);
        chk("len", settings.eval_len, LEN_SPD_LO);
        chk("speed", settings.speed, 1);
        u_kp.press(K_OK, 1);
        chk("count", settings.count, CNT_1);
        u_kp.press(K_OK, 3);
        u_kp.press(K_DN, 10);
        u_kp.press(K_OK, 1);
        chk("len", settings.eval_len, LEN_MIN);
        chk("speed", settings.speed, 0);
        u_kp.press(K_OK, 4);
        u_kp.press(K_CUT, 123);
        u_kp.press(K_OK, 1);
        chk("len", settings.eval_len, LEN_MAX);
    endtask

    task automatic t_range();
        u_kp.press(K_CAL, 3);
        chk("menu", display.menu, ST_RANGE);
        u_kp.press(K_DN, 5);
        u_kp.press(K_OK, 1);
        chk("range", settings.range, RNG_LAST);
        chk("resolution", settings.resolution, RNG_LAST);
        u_kp.press(K_CAL, 3);
        u_kp.press(K_CUT, 1);
        u_kp.press(K_ESC, 1);
        chk("range", settings.range, RNG_LAST);
        u_kp.press(K_CAL, 3);
        u_kp.press(K_CUT, 2);
        u_kp.press(K_OK, 1);
        chk("range", settings.range, 3'h2);
    endtask

    task automatic t_std();
        u_kp.press(K_CAL, 2);
        chk("menu", display.menu, ST_STD);
        u_kp.press(K_CUT, 1);
        u_kp.press(K_OK, 1);
        chk("standard", settings.standard, STD_JIS82);
        chk("filter", settings.filter, FIL_2RC);
        u_kp.press(K_CAL, 2);
        u_kp.press(K_DN, 2);
        u_kp.press(K_OK, 1);
        chk("standard", settings.standard, STD_LAST);
        chk("filter", settings.filter, FIL_PC50);
        u_kp.press(K_CAL, 2);
        u_kp.press(K_CUT, 1);
        u_kp.press(K_ESC, 1);
        chk("standard", settings.standard, STD_LAST);
    endtask

    task automatic t_prf();
        u_kp.press(K_PRF, 1);
        chk("menu", display.menu, ST_PRF);
        u_kp.press(K_CUT, 1);
        u_kp.press(K_OK, 1);
        chk("profile", settings.profile, PRF_LAST);
        u_kp.press(K_PRF, 1);
        u_kp.press(K_CUT, 1);
        u_kp.press(K_ESC, 1);
        chk("profile", settings.profile, PRF_LAST);
        u_kp.press(K_PRF, 1);
        u_kp.press(K_DN, 2);
        u_kp.press(K_OK, 1);
        chk("profile", settings.profile, 2'h0);
    endtask

    task automatic t_apb();
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", er, 1);
        chk("rdata", rd, 0);
        apb(1'b1, ADDR_CONTROL, 32'h3);
        chk("range", settings.range, RNG_AUTO);
        chk("standard", settings.standard, STD_JIS01);
        chk("prepost", settings.prepost, 1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", rd[3:0], 4'h0);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_reset();
        t_cut();
        t_speed();
        t_prepost();
        t_len();
        t_range();
        t_std();
        t_prf();
        t_apb();
        give_verdict();
    end

    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule

bind msm_settings msm_settings_properties u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .settings(settings), .display(display));
